// *** cag_map.svh ***
// Purpose: Offsets, field positions and reset values of the address generator
// Assumes: One 32-bit AHB-Lite word per register
// Notes:   Definitions only
`ifndef CAG_MAP_SVH
`define CAG_MAP_SVH

// ============================================================
// Register offsets (byte addresses)
`define CAG_MODE_REG_OFS   8'h00
`define CAG_LAST_BASE_OFS  8'h04
`define CAG_LAST_ADDR_OFS  8'h08

// ============================================================
// Address mode register layout
`define CAG_MODE_W         2
`define CAG_BK_W           5
`define CAG_BK_FIRST_LSB   16
`define CAG_BK_SECOND_LSB  21
`define CAG_MODE_REG_WMASK 32'h03ff_ffff
`define CAG_MODE_REG_RST   32'h0000_0000

// ============================================================
// Eligible register window: index 4 to 7 of either file
`define CAG_CIRC_IDX_HI    3'h1

`endif

// *** cag_pkg.sv ***
// Purpose: Types shared by the address generator files
// Assumes: Nothing beyond SystemVerilog packages
// Notes:   Constants live in cag_map.svh
package cag_pkg;

    // ============================================================
    // Enumerations
    typedef enum logic [1:0] {
        CAG_MODE_LINEAR = 2'h0,
        CAG_MODE_CIRC_FIRST = 2'h1,
        CAG_MODE_CIRC_SECOND = 2'h2,
        CAG_MODE_RESERVED = 2'h3
    } cag_mode_t;

    // Value equals the left shift applied to the offset
    typedef enum logic [1:0] {
        CAG_SIZE_BYTE = 2'h0,
        CAG_SIZE_HALF = 2'h1,
        CAG_SIZE_WORD = 2'h2,
        CAG_SIZE_DWORD = 2'h3
    } cag_size_t;

    typedef enum logic [1:0] {
        CAG_OP_LDST = 2'h0,
        CAG_OP_LDST_NDW = 2'h1,
        CAG_OP_SCALED_ADD = 2'h2
    } cag_op_t;

    // ============================================================
    // Request from decode and answer to the memory path
    typedef struct packed {
        logic valid;
        logic unit_two;
        logic file_second;
        logic [4:0] reg_idx;
        cag_op_t op;
        cag_size_t size;
        logic sub;
        logic post;
        logic nonscaled;
        logic [31:0] base;
        logic [31:0] offset;
    } cag_req_t;

    typedef struct packed {
        logic valid;
        logic circ;
        logic [31:0] mem_addr;
        logic [31:0] new_base;
    } cag_resp_t;

endpackage

// *** cag_wrap.sv ***
// Purpose: Keeps the bits above the circular window equal to a reference
// Assumes: bk selects a window of 2^(bk+1) bytes
// Notes:   Purely combinational; with circ low the raw value passes through
`timescale 1ns/1ps
`default_nettype none
module cag_wrap (
    // Operands
    input wire logic [31:0] base,
    input wire logic [31:0] raw,
    input wire logic circ,
    input wire logic [4:0] bk,
    // Result
    output logic [31:0] wrapped,
    output logic [31:0] mask
);
    always_comb begin
        // bk of 31 shifts all ones out, so the whole word may change
        mask = circ ? ~(32'hffff_fffe << bk) : 32'hffff_ffff;
        wrapped = (raw & mask) | (base & ~mask);
    end
endmodule // cag_wrap
`default_nettype wire

// *** cag_top.sv ***
// Purpose: Linear and circular address generation for the two data units
// Assumes: AHB-Lite register access, request accepted every cycle
// Notes:   One cycle from request to answer
//
// Register access over AHB-Lite and the register addresses are this design's own decisions.
`include "cag_map.svh"
`timescale 1ns/1ps
`default_nettype none
module cag_top #(
    parameter int LANES = 8
) (
    // Clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // AHB-Lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    // Decode request
    input wire cag_pkg::cag_req_t req,
    // Memory path answer
    output cag_pkg::cag_resp_t resp,
    output logic [LANES-1:0][31:0] lane_addr
);

    // ============================================================
    // Elaboration check
    if (LANES < 1 || LANES > 8) begin : g_bad_lanes
        $error("cag_top: LANES must lie between 1 and 8");
    end

    // ============================================================
    // Register bus
    logic [31:0] address_mode_register;
    logic [31:0] next_address_mode_register;
    logic [31:0] last_base;
    logic [31:0] next_last_base;
    logic [31:0] last_addr;
    logic [31:0] next_last_addr;
    logic wr_pend;
    logic next_wr_pend;
    logic [7:0] wr_ofs;
    logic [7:0] next_wr_ofs;
    logic [31:0] next_hrdata;
    logic take;
    logic [31:0] mode_view;

    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign take = hsel & htrans[1] & hready;

    always_comb begin
        next_wr_pend = take & hwrite;
        next_wr_ofs = take ? haddr[7:0] : wr_ofs;
        next_address_mode_register = address_mode_register;
        if (wr_pend && wr_ofs == `CAG_MODE_REG_OFS) begin
            next_address_mode_register = hwdata & `CAG_MODE_REG_WMASK;
        end
        // A read right behind a write sees the value being written
        mode_view = next_address_mode_register;
        next_hrdata = hrdata;
        if (take && !hwrite) begin
            case (haddr[7:0])
                `CAG_MODE_REG_OFS: next_hrdata = mode_view;
                `CAG_LAST_BASE_OFS: next_hrdata = next_last_base;
                `CAG_LAST_ADDR_OFS: next_hrdata = next_last_addr;
                default: next_hrdata = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            address_mode_register <= `CAG_MODE_REG_RST;
            wr_pend <= 1'b0;
            wr_ofs <= 8'h00;
            hrdata <= 32'h0000_0000;
        end else begin
            address_mode_register <= next_address_mode_register;
            wr_pend <= next_wr_pend;
            wr_ofs <= next_wr_ofs;
            hrdata <= next_hrdata;
        end
    end

    // ============================================================
    // Mode selection
    logic eligible;
    logic [2:0] mode_idx;
    cag_pkg::cag_mode_t mode;
    logic circ;
    logic [4:0] bk;
    logic [4:0] block_size_field_first;
    logic [4:0] block_size_field_second;

    assign block_size_field_first = address_mode_register[`CAG_BK_FIRST_LSB +: `CAG_BK_W];
    assign block_size_field_second = address_mode_register[`CAG_BK_SECOND_LSB +: `CAG_BK_W];

    always_comb begin
        // Register file must match the unit, index 4 to 7 only
        eligible = (req.unit_two == req.file_second)
            && (req.reg_idx[4:2] == `CAG_CIRC_IDX_HI);
        mode_idx = {req.file_second, req.reg_idx[1:0]};
        mode = cag_pkg::cag_mode_t'(address_mode_register[{mode_idx, 1'b0} +: `CAG_MODE_W]);
        // Reserved code falls back to linear
        circ = eligible && (mode == cag_pkg::CAG_MODE_CIRC_FIRST
            || mode == cag_pkg::CAG_MODE_CIRC_SECOND);
        bk = (mode == cag_pkg::CAG_MODE_CIRC_SECOND) ? block_size_field_second
            : block_size_field_first;
    end

    // ============================================================
    // Address arithmetic
    logic [31:0] scaled;
    logic [31:0] raw;
    logic [31:0] calc;
    logic [31:0] calc_mask;
    logic [31:0] access;

    always_comb begin
        if (req.op == cag_pkg::CAG_OP_LDST_NDW && req.nonscaled) begin
            scaled = req.offset;
        end else begin
            scaled = req.offset << req.size;
        end
        raw = req.sub ? req.base - scaled : req.base + scaled;
    end

    // Window is 2^(bk+1) bytes, independent of access size
    cag_wrap u_calc (
        .base(req.base),
        .raw(raw),
        .circ(circ),
        .bk(bk),
        .wrapped(calc),
        .mask(calc_mask)
    );

    always_comb begin
        if (req.post && req.op != cag_pkg::CAG_OP_SCALED_ADD) begin
            access = req.base;
        end else begin
            access = calc;
        end
    end

    // ============================================================
    // Byte lanes: each logically adjacent byte wraps on its own
    logic [LANES-1:0][31:0] next_lane_addr;

    for (genvar i = 0; i < LANES; i++) begin : g_lane
        cag_wrap u_lane (
            .base(access),
            .raw(access + 32'(i)),
            .circ(circ),
            .bk(bk),
            .wrapped(next_lane_addr[i]),
            .mask()
        );
    end

    // ============================================================
    // Answer and status registers
    cag_pkg::cag_resp_t next_resp;

    always_comb begin
        next_resp.valid = req.valid;
        next_resp.circ = circ;
        next_resp.mem_addr = access;
        next_resp.new_base = calc;
        next_last_base = req.valid ? calc : last_base;
        next_last_addr = req.valid ? access : last_addr;
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            resp <= '0;
            lane_addr <= '0;
            last_base <= 32'h0000_0000;
            last_addr <= 32'h0000_0000;
        end else begin
            resp <= next_resp;
            lane_addr <= next_lane_addr;
            last_base <= next_last_base;
            last_addr <= next_last_addr;
        end
    end

    // ============================================================
    // Checks; helper copies of the request feed only these
    cag_pkg::cag_req_t req_q;
    logic [31:0] mask_q;
    logic [31:0] scaled_q;
    logic elig_q;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            req_q <= '0;
            mask_q <= 32'h0000_0000;
            scaled_q <= 32'h0000_0000;
            elig_q <= 1'b0;
        end else begin
            req_q <= req;
            mask_q <= calc_mask;
            scaled_q <= scaled;
            elig_q <= eligible;
        end
    end

    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    sequence s_req_taken;
        req.valid;
    endsequence

    sequence s_mode_write;
        take && hwrite && haddr[7:0] == `CAG_MODE_REG_OFS;
    endsequence

    a_post_old_base: assert property (
        s_req_taken ##1 (req_q.post && req_q.op != cag_pkg::CAG_OP_SCALED_ADD)
        |-> resp.mem_addr == req_q.base)
        else $error("post form did not access old base");

    a_pre_new_addr: assert property (
        s_req_taken ##1 !req_q.post |-> resp.mem_addr == resp.new_base)
        else $error("pre form did not access new address");

    a_upper_bits_kept: assert property (
        s_req_taken ##1 resp.circ |-> (resp.new_base & ~mask_q) == (req_q.base & ~mask_q))
        else $error("circular result changed bits above window");

    a_linear_sum: assert property (
        s_req_taken ##1 (!resp.circ && !req_q.sub)
        |-> resp.new_base == req_q.base + (req_q.op == cag_pkg::CAG_OP_LDST_NDW
            && req_q.nonscaled ? req_q.offset : req_q.offset << req_q.size))
        else $error("linear add result wrong");

    a_linear_diff: assert property (
        s_req_taken ##1 (!resp.circ && req_q.sub)
        |-> resp.new_base == req_q.base - (req_q.op == cag_pkg::CAG_OP_LDST_NDW
            && req_q.nonscaled ? req_q.offset : req_q.offset << req_q.size))
        else $error("linear subtract result wrong");

    a_offset_shift: assert property (
        s_req_taken ##1 1'b1 |-> scaled_q == ((req_q.op == cag_pkg::CAG_OP_LDST_NDW
            && req_q.nonscaled) ? req_q.offset : req_q.offset << req_q.size))
        else $error("offset shift wrong");

    a_reserved_linear: assert property (
        s_req_taken ##1 ($past(mode) == cag_pkg::CAG_MODE_RESERVED) |-> !resp.circ)
        else $error("reserved mode used circular arithmetic");

    a_ineligible_linear: assert property (
        s_req_taken ##1 !elig_q |-> !resp.circ)
        else $error("ineligible register used circular mode");

    a_lane_window: assert property (
        s_req_taken ##1 resp.circ
        |-> (lane_addr[LANES-1] & ~mask_q) == (resp.mem_addr & ~mask_q))
        else $error("byte lane left circular window");

    a_lane_adjacent: assert property (
        s_req_taken ##1 1'b1
        |-> ((lane_addr[LANES-1] - resp.mem_addr) & mask_q) == (32'(LANES - 1) & mask_q))
        else $error("byte lanes not logically adjacent");

    a_mode_update: assert property (
        s_mode_write ##1 1'b1 |=> address_mode_register == ($past(hwdata) & `CAG_MODE_REG_WMASK))
        else $error("mode register not written");

    a_window_size: assert property (
        s_req_taken ##1 resp.circ |-> mask_q + 32'h1 == (32'h2 << $past(bk)))
        else $error("window size differs from field");

endmodule // cag_top
`default_nettype wire

// *** cag_cpu_model.sv ***
// Purpose: Decode-side model that issues one address request per command
// Assumes: Commands arrive just after a rising edge of hclk
// Notes:   Idle fields invert each cycle so a stale request is never mistaken for live
`timescale 1ns/1ps
`default_nettype none
module cag_cpu_model (
    // Clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // Command from the bench
    input wire logic go,
    input wire cag_pkg::cag_req_t cmd,
    // Request to the generator
    output cag_pkg::cag_req_t req
);
    cag_pkg::cag_req_t next_req;

    always_comb begin
        next_req = cag_pkg::cag_req_t'(~req);
        next_req.valid = 1'b0;
        if (go) begin
            next_req = cmd;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            req <= '0;
        end else begin
            req <= next_req;
        end
    end
endmodule // cag_cpu_model
`default_nettype wire

// *** circular_address_generator_tb.sv ***
// Purpose: Self-checking bench for the address generator
// Assumes: Zero-wait AHB-Lite slave, answer one cycle after a request
// Notes:   Reset value first, then table rows, byte-lane wrap, register map and a second reset
`timescale 1ns/1ps
`default_nettype none
module circular_address_generator_tb;
    typedef struct {
        logic [31:0] mode_word;
        cag_pkg::cag_req_t rq;
        logic [31:0] mem;
        logic [31:0] nb;
        logic circ;
    } cag_row_t;
    logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0, go = 1'b0;
    logic hready, hreadyout, hresp;
    logic [1:0] htrans = 2'h0;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd;
    cag_pkg::cag_req_t cmd = '0, req;
    cag_pkg::cag_resp_t resp;
    logic [7:0][31:0] lane_addr;
    cag_row_t rows [14];
    int fail_count = 0, n_tests = 0;
    assign hready = hreadyout;

    cag_top #(.LANES(8)) uut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hready),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .req(req), .resp(resp),
        .lane_addr(lane_addr));
    cag_cpu_model cpu (.hclk(hclk), .hresetn(hresetn), .go(go), .cmd(cmd), .req(req));

    initial begin
        forever #4 hclk = ~hclk;
    end

    function automatic cag_pkg::cag_req_t mk(logic u2, logic f2, logic [4:0] idx,
        logic [1:0] op, logic [1:0] sz, logic sub, logic post, logic ns,
        logic [31:0] base, logic [31:0] off);
        mk = '{1'b1, u2, f2, idx, cag_pkg::cag_op_t'(op), cag_pkg::cag_size_t'(sz),
            sub, post, ns, base, off};
    endfunction

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            fail_count++;
            $display("ERROR t=%0t seen=%h expected=%h", $time, seen, exp);
        end
    endtask

    // ============================================================
    // AHB-Lite single word transfer; waits on hready at both phases
    task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] d);
        @(posedge hclk);
        hsel <= 1'b1;
        haddr <= a;
        hwrite <= wr;
        htrans <= 2'h2;
        @(posedge hclk);
        while (hready !== 1'b1) @(posedge hclk);
        htrans <= 2'h0;
        hwdata <= d;
        @(posedge hclk);
        while (hready !== 1'b1) @(posedge hclk);
        rd = hrdata;
    endtask

    task automatic issue(input cag_pkg::cag_req_t c);
        @(posedge hclk);
        cmd <= c;
        go <= 1'b1;
        @(posedge hclk);
        go <= 1'b0;
        @(posedge hclk);
        #1;
    endtask

    task automatic give_verdict();
        $display("comparisons %0d mismatches %0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    initial begin
        repeat (5000) @(posedge hclk);
        fail_count++;
        give_verdict();
    end

    initial begin
        rows[0] = '{32'h0004_0001, mk(0, 0, 4, 0, 2, 0, 0, 0, 32'h100, 32'h9), 32'h104, 32'h104, 1};
        rows[1] = '{32'h0004_0001, mk(0, 0, 4, 2, 1, 0, 0, 0, 32'h100, 32'h13), 32'h106, 32'h106, 1};
        rows[2] = '{32'h0004_0001, mk(0, 0, 4, 0, 2, 0, 1, 0, 32'h100, 32'h9), 32'h100, 32'h104, 1};
        rows[3] = '{32'h0004_0001, mk(0, 0, 8, 0, 2, 1, 0, 0, 32'h100, 32'h9), 32'hdc, 32'hdc, 0};
        rows[4] = '{32'h0004_0001, mk(1, 0, 4, 0, 2, 0, 0, 0, 32'h100, 32'h9), 32'h124, 32'h124, 0};
        rows[5] = '{32'h0004_0001, mk(0, 0, 4, 0, 2, 1, 0, 0, 32'h100, 32'h9), 32'h11c, 32'h11c, 1};
        rows[6] = '{32'h0, mk(0, 0, 3, 0, 3, 0, 0, 0, 32'h0, 32'h2), 32'h10, 32'h10, 0};
        rows[7] = '{32'h0, mk(0, 0, 3, 1, 3, 0, 0, 1, 32'h10, 32'h3), 32'h13, 32'h13, 0};
        rows[8] = '{32'h0, mk(0, 0, 9, 0, 0, 0, 0, 0, 32'hffff_ffff, 32'h1), 32'h0, 32'h0, 0};
        rows[9] = '{32'h0003_0001, mk(0, 0, 4, 0, 2, 0, 0, 0, 32'h2a, 32'h2), 32'h22, 32'h22, 1};
        rows[10] = '{32'h0040_0200, mk(1, 1, 4, 0, 0, 0, 0, 0, 32'h40, 32'h9), 32'h41, 32'h41, 1};
        rows[11] = '{32'h0000_000c, mk(0, 0, 5, 0, 0, 0, 0, 0, 32'h40, 32'h9), 32'h49, 32'h49, 0};
        rows[12] = '{32'h0040_0008, mk(0, 0, 5, 0, 0, 0, 0, 0, 32'h40, 32'h9), 32'h41, 32'h41, 1};
        rows[13] = '{32'h0004_0001, mk(0, 0, 4, 2, 1, 1, 1, 0, 32'h100, 32'h13), 32'h11a, 32'h11a, 1};
        repeat (10) @(posedge hclk);
        hresetn <= 1'b1;
        bus(1'b0, 32'h0, 32'h0);
        check(rd, 32'h0);
        check({31'h0, hresp}, 32'h0);
        check({31'h0, hreadyout}, 32'h1);
        foreach (rows[i]) begin
            bus(1'b1, 32'h0, rows[i].mode_word);
            issue(rows[i].rq);
            check({31'h0, resp.valid}, 32'h1);
            check(resp.mem_addr, rows[i].mem);
            check(resp.new_base, rows[i].nb);
            check({31'h0, resp.circ}, {31'h0, rows[i].circ});
        end
        // ============================================================
        // Word wrap at the top of a 16-byte buffer, buffer kept no smaller than access
        bus(1'b1, 32'h0, 32'h0003_0001);
        issue(mk(0, 0, 4, 0, 2, 0, 0, 0, 32'h2e, 32'h0));
        for (int i = 0; i < 8; i++) begin
            check(lane_addr[i], 32'h20 | ((32'he + i) & 32'hf));
        end
        bus(1'b0, 32'h8, 32'h0);
        check(rd, 32'h2e);
        bus(1'b1, 32'h4, 32'h1234_5678);
        bus(1'b0, 32'h4, 32'h0);
        check(rd, 32'h2e);
        bus(1'b1, 32'hc, 32'hffff_ffff);
        bus(1'b0, 32'hc, 32'h0);
        check(rd, 32'h0);
        bus(1'b1, 32'h0, 32'hffff_ffff);
        bus(1'b0, 32'h0, 32'h0);
        check(rd, 32'h03ff_ffff);
        // Second reset in mid-run clears the mode register and the answer
        @(posedge hclk);
        hresetn <= 1'b0;
        repeat (3) @(posedge hclk);
        #1;
        check(resp.mem_addr, 32'h0);
        check(lane_addr[7], 32'h0);
        check({31'h0, hreadyout}, 32'h1);
        @(posedge hclk);
        hresetn <= 1'b1;
        bus(1'b0, 32'h0, 32'h0);
        check(rd, 32'h0);
        give_verdict();
    end
endmodule // circular_address_generator_tb
`default_nettype wire
